//--- core/alu_pkg.sv
/*
 Shared types and constants for the accumulator datapath fragment.
 Assumes a decoder that issues one operation per request.
*/
package alu_pkg;
	localparam int DATA_W = 8;
	localparam int NIB_W  = 4;
	localparam int ADDR_W = 8;
	localparam logic [7:0] WORK_RST = 8'h00;

	typedef enum logic [2:0] {
		OP_NONE                = 3'b000,
		SUM_INTO_MEMORY_OP     = 3'b001,
		CONJOIN_MEM_TO_WORK_OP = 3'b010,
		CONJOIN_IMM_TO_WORK_OP = 3'b011,
		CONJOIN_INTO_MEMORY_OP = 3'b100
	} op_t;

	typedef struct packed {
		op_t              op;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] imm;
	} req_t;

	typedef struct packed {
		logic overflow_flag;
		logic zero_flag;
		logic half_carry_flag;
		logic carry_flag;
	} flags_t;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_READ  = 2'b01,
		ST_EXEC  = 2'b10
	} state_t;
endpackage

//--- core/data_ram.sv
/*
 Small data memory with registered read data.
 Assumes one clock; write and read may occur in the same cycle.
*/
`timescale 1ns/1ns
module data_ram
	import alu_pkg::*;
#(
	parameter int AW = ADDR_W,
	parameter int DW = DATA_W
) (
	input  wire logic          sys_clk_i,
	input  wire logic          we_i,
	input  wire logic [AW-1:0] waddr_i,
	input  wire logic [DW-1:0] wdata_i,
	input  wire logic [AW-1:0] raddr_i,
	output logic      [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];

	// Write port
	always_ff @(posedge sys_clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
	end

	// Registered read
	always_ff @(posedge sys_clk_i) begin
		rdata_o <= mem[raddr_i];
	end
endmodule

//--- core/acc_memory_add_and_ops.sv
/*
 Accumulator datapath for memory add and the three AND forms, with its data memory.
 Assumes the decoder raises req_valid_i only while ready_o is high.
*/
// Operation
// - Sum memory add writes working register plus memory back, updating overflow, zero, half carry, carry.
// - Memory AND into working register updates only the zero flag.
// - Immediate AND into working register updates only the zero flag.
// - Working register AND memory computes with data memory as destination.
`timescale 1ns/1ns
module acc_memory_add_and_ops
	import alu_pkg::*;
#(
	parameter int AW = ADDR_W
) (
	input  wire logic              sys_clk_i,
	input  wire logic              rst_i,
	input  wire logic              req_valid_i,
	input  wire req_t              req_i,
	output logic                   ready_o,
	output logic                   done_o,
	output logic      [DATA_W-1:0] working_register_o,
	output flags_t                 flags_o,
	input  wire logic              load_valid_i,
	input  wire logic [AW-1:0]     load_addr_i,
	input  wire logic [DATA_W-1:0] load_data_i
);
	// Address width must fit inside the request's address field
	if (AW < 1 || AW > ADDR_W) begin : g_aw_check
		$error("AW out of range");
	end

	state_t            state_r;
	req_t              req_r;
	logic [DATA_W-1:0] work_r;
	flags_t            flags_r;
	logic              done_r;
	logic [DATA_W-1:0] mem_rd;
	logic              alu_we;
	logic [DATA_W-1:0] result;
	flags_t            flags_nxt;
	logic [DATA_W-1:0] operand;

	// Zero test used by every operation
	function automatic logic is_zero(input logic [DATA_W-1:0] v);
		return (v == '0);
	endfunction

	// Memory access: decoder preload when idle, else writeback
	data_ram #(.AW(AW), .DW(DATA_W)) u_ram (
		.sys_clk_i (sys_clk_i),
		.we_i      (alu_we | (load_valid_i & (state_r == ST_IDLE))),
		.waddr_i   (alu_we ? req_r.addr[AW-1:0] : load_addr_i),
		.wdata_i   (alu_we ? result : load_data_i),
		.raddr_i   (req_r.addr[AW-1:0]),
		.rdata_o   (mem_rd)
	);

	// Sequencer: take request, wait for read data, execute
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			state_r <= ST_IDLE;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (req_valid_i && req_i.op != OP_NONE) begin
						state_r <= ST_READ;
					end
				end
				ST_READ: state_r <= ST_EXEC;
				ST_EXEC: state_r <= ST_IDLE;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Request capture
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			req_r <= '0;
		end else if (state_r == ST_IDLE && req_valid_i) begin
			req_r <= req_i;
		end
	end

	// Operand and result selection
	always_comb begin
		logic [NIB_W:0]    low_sum;
		logic [DATA_W:0]   full_sum;
		low_sum   = '0;
		full_sum  = '0;
		operand   = (req_r.op == CONJOIN_IMM_TO_WORK_OP) ? req_r.imm : mem_rd;
		result    = work_r & operand;
		flags_nxt = flags_r;
		case (req_r.op)
			SUM_INTO_MEMORY_OP: begin
				low_sum  = {1'b0, work_r[NIB_W-1:0]} + {1'b0, mem_rd[NIB_W-1:0]};
				full_sum = {1'b0, work_r} + {1'b0, mem_rd};
				result   = full_sum[DATA_W-1:0];
				flags_nxt.carry_flag      = full_sum[DATA_W];
				flags_nxt.half_carry_flag = low_sum[NIB_W];
				flags_nxt.overflow_flag   = (work_r[DATA_W-1] == mem_rd[DATA_W-1])
					&& (result[DATA_W-1] != work_r[DATA_W-1]);
				flags_nxt.zero_flag       = is_zero(result);
			end
			CONJOIN_MEM_TO_WORK_OP,
			CONJOIN_IMM_TO_WORK_OP,
			CONJOIN_INTO_MEMORY_OP: begin
				flags_nxt.zero_flag = is_zero(result);
			end
			default: begin
				result = work_r;
			end
		endcase
	end

	// Memory is destination for add and AND-into-memory
	assign alu_we = (state_r == ST_EXEC) &&
		(req_r.op == SUM_INTO_MEMORY_OP || req_r.op == CONJOIN_INTO_MEMORY_OP);

	// Working register: written only by the AND-into-register forms
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			work_r <= WORK_RST;
		end else if (state_r == ST_EXEC &&
			(req_r.op == CONJOIN_MEM_TO_WORK_OP || req_r.op == CONJOIN_IMM_TO_WORK_OP)) begin
			work_r <= result;
		end
	end

	// Status flags
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			flags_r <= '0;
		end else if (state_r == ST_EXEC) begin
			flags_r <= flags_nxt;
		end
	end

	// Completion pulse
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			done_r <= 1'b0;
		end else begin
			done_r <= (state_r == ST_EXEC);
		end
	end

	assign ready_o            = (state_r == ST_IDLE);
	assign done_o             = done_r;
	assign working_register_o = work_r;
	assign flags_o            = flags_r;
endmodule

//--- verification/alu_props.sv
/* Port checker for the datapath.
 Assumes binding to the top module. */
`timescale 1ns/1ns
module alu_props
	import alu_pkg::*;
(
	input wire logic   sys_clk_i,
	input wire logic   rst_i,
	input wire logic   req_valid_i,
	input wire req_t   req_i,
	input wire logic   ready_o,
	input wire logic   done_o,
	input wire logic [DATA_W-1:0] working_register_o,
	input wire flags_t flags_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// Taken request
	wire logic go = ready_o && req_valid_i;
	a_busy_done: assert property (go && req_i.op != OP_NONE |=> !ready_o ##1 !ready_o ##1 done_o)
		else $error("done not three cycles after request");
	a_sum_keeps_work: assert property (go && req_i.op == SUM_INTO_MEMORY_OP |-> ##3
		working_register_o == $past(working_register_o, 3)) else $error("memory add changed accumulator");
	a_and_zero_only: assert property (go && req_i.op inside {CONJOIN_MEM_TO_WORK_OP,
		CONJOIN_IMM_TO_WORK_OP, CONJOIN_INTO_MEMORY_OP} |-> ##3 {flags_o.overflow_flag, flags_o.half_carry_flag,
		flags_o.carry_flag} == $past({flags_o.overflow_flag, flags_o.half_carry_flag, flags_o.carry_flag}, 3))
		else $error("AND changed a flag other than zero");
	a_and_zero_val: assert property (go && req_i.op inside {CONJOIN_MEM_TO_WORK_OP,
		CONJOIN_IMM_TO_WORK_OP} |-> ##3 flags_o.zero_flag == (working_register_o == 8'h00))
		else $error("zero flag wrong after AND");
	a_imm_result: assert property (go && req_i.op == CONJOIN_IMM_TO_WORK_OP |-> ##3
		working_register_o == ($past(working_register_o, 3) & $past(req_i.imm, 3))) else $error("AND immediate wrong");
	a_mem_keeps_work: assert property (go && req_i.op == CONJOIN_INTO_MEMORY_OP |-> ##3
		working_register_o == $past(working_register_o, 3)) else $error("memory AND changed accumulator");
endmodule
bind acc_memory_add_and_ops alu_props u_props (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
	.req_i(req_i), .ready_o(ready_o), .done_o(done_o), .working_register_o(working_register_o), .flags_o(flags_o));

//--- verification/decoder_model.sv
/* Decoder model issuing requests and memory preloads.
 Assumes inputs are driven at the falling clock edge. */
`timescale 1ns/1ns
module decoder_model
	import alu_pkg::*;
(
	input  wire logic   sys_clk_i,
	input  wire logic   done_i,
	output logic        req_valid_o = 1'b0,
	output req_t        req_o = '0,
	output logic        load_valid_o = 1'b0,
	output logic [7:0]  load_addr_o = 8'h00,
	output logic [7:0]  load_data_o = 8'h00
);
	// One preload write, made while idle
	task automatic preload(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_i) {load_valid_o, load_addr_o, load_data_o} = {1'b1, a, d};
		@(negedge sys_clk_i) load_valid_o = 1'b0;
	endtask
	// One request, then a bounded wait for done
	task automatic issue(input op_t op, input logic [7:0] a, input logic [7:0] i, output bit got);
		got = 0;
		@(negedge sys_clk_i) {req_valid_o, req_o} = {1'b1, op, a, i};
		@(negedge sys_clk_i) req_valid_o = 1'b0;
		req_o = {OP_NONE, ~a, ~i};
		for (int n = 0; n < 6 && !got; n++) begin
			got = done_i;
			if (!got) @(negedge sys_clk_i);
		end
	endtask
endmodule

//--- verification/testbench.sv
/* Self-checking bench for the datapath.
 Assumes the decoder model and checker are compiled first. */
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin error_cnt++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
	import alu_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic req_valid_i, ready_o, done_o, load_valid_i;
	req_t req_i;
	flags_t flags_o;
	logic [7:0] working_register_o, load_addr_i, load_data_i;
	int error_cnt = 0;
	int checks = 0;
	bit got;
	acc_memory_add_and_ops u_acc_memory_add_and_ops (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .req_valid_i(req_valid_i),
		.req_i(req_i), .ready_o(ready_o), .done_o(done_o), .working_register_o(working_register_o), .flags_o(flags_o),
		.load_valid_i(load_valid_i), .load_addr_i(load_addr_i), .load_data_i(load_data_i));
	decoder_model u_dec (.sys_clk_i(sys_clk_i), .done_i(done_o), .req_valid_o(req_valid_i), .req_o(req_i),
		.load_valid_o(load_valid_i), .load_addr_o(load_addr_i), .load_data_o(load_data_i));
	// Clock at 4 ns
	initial forever #2 sys_clk_i = ~sys_clk_i;
	task automatic final_report;
		$display("checks %0d errors %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// Runs one operation and compares accumulator and flags
	task automatic op_chk(input op_t op, input logic [7:0] a, input logic [7:0] i, input logic [3:0] f);
		u_dec.issue(op, a, i, got);
		if (!got) begin
			error_cnt++;
			final_report();
		end
		`CHK(working_register_o, 8'h00)
		`CHK(flags_o, f)
	endtask
	// Memory add, then AND from memory and immediate
	task automatic t_add_and;
		u_dec.preload(8'h05, 8'h3C);
		op_chk(SUM_INTO_MEMORY_OP, 8'h05, 8'h00, 4'b0000);
		op_chk(CONJOIN_MEM_TO_WORK_OP, 8'h05, 8'h00, 4'b0100);
		op_chk(CONJOIN_IMM_TO_WORK_OP, 8'h00, 8'hFF, 4'b0100);
		op_chk(SUM_INTO_MEMORY_OP, 8'h05, 8'h00, 4'b0000);
		$display("add and done");
	endtask
	// AND into memory clears the byte, seen by a later add
	task automatic t_and_mem;
		op_chk(CONJOIN_INTO_MEMORY_OP, 8'h05, 8'h00, 4'b0100);
		op_chk(SUM_INTO_MEMORY_OP, 8'h05, 8'h00, 4'b0100);
		$display("and memory done");
	endtask
	// Empty opcode is ignored
	task automatic t_refused;
		u_dec.issue(OP_NONE, 8'h05, 8'h00, got);
		`CHK(got, 1'b0)
		$display("refused done");
	endtask
	initial begin
		repeat (10) @(negedge sys_clk_i);
		rst_i = 1'b0;
		t_add_and();
		t_and_mem();
		t_refused();
		final_report();
	end
endmodule
